// *** core/emt_timer.sv ***
// Eight bit modulo timer with control nibble and data buffer access
`timescale 1ns/1ps

// What this block does
// - Control bit 3 at 33H runs the counter; writing bit 2 clears it.
// - Control bits 1 and 0 select the counter clock source.
// - Count reads at peripheral 05H; writes to the counter are ignored.
// - Match value written at peripheral 06H; reading it gives nothing back.
// - Count equal to a nonzero match value while running sets match flag, bit 0 at 3FH.
// - Built from counter, match register, comparator and clock selector.
// - Run bit low stops the counter; only a bit 2 clear write still changes it.
module emt_timer
	import emt_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       rfWrite,
	input  wire logic [7:0] rfAddr,
	input  wire logic [3:0] rfWriteData,
	output logic      [3:0] rfReadData,
	input  wire logic       peripheralWriteOp,
	input  wire logic       peripheralReadOp,
	input  wire logic [7:0] periphAddr,
	input  wire logic [7:0] peripheralDataBufferIn,
	output logic      [7:0] peripheralDataBufferOut,
	input  wire logic       carrierClockPin,
	output logic            timerMatchFlag
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic       countRunBit;
		logic [1:0] clockSelect;
		logic [7:0] timerCountValue;
		logic [7:0] matchLimitValue;
		logic [7:0] prescale;
		logic       matchFlag;
		logic [1:0] extSync;
		logic       extPrev;
		logic [3:0] rfRead;
		logic [7:0] dbfRead;
	} emt_state_t;

	// Reset image of all state
	localparam emt_state_t EMT_RESET_STATE = '{
		countRunBit:     EMT_CTRL_RESET[EMT_RUN_BIT],
		clockSelect:     {EMT_CTRL_RESET[EMT_SEL_HI], EMT_CTRL_RESET[EMT_SEL_LO]},
		timerCountValue: EMT_COUNT_RESET,
		matchLimitValue: EMT_MATCH_RESET,
		prescale:        '0,
		matchFlag:       1'b0,
		extSync:         '0,
		extPrev:         1'b0,
		rfRead:          '0,
		dbfRead:         '0
	};

	emt_state_t state;
	emt_state_t next_state;
	logic       tick;
	logic       matchNow;
	logic       clrWrite;
	logic       ctrlWrite;
	logic       irqClrWrite;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		next_state = state;
		next_state.prescale = state.prescale + 8'h01;
		next_state.extSync = {state.extSync[0], carrierClockPin};
		next_state.extPrev = state.extSync[1];
		ctrlWrite = rfWrite && (rfAddr == EMT_RF_CTRL);
		clrWrite = ctrlWrite && rfWriteData[EMT_CLR_BIT];
		irqClrWrite = rfWrite && (rfAddr == EMT_RF_IRQ) && !rfWriteData[EMT_FLAG_BIT];
		// Clock source selector
		unique case (state.clockSelect)
			EMT_SEL_DIV32:  tick = (state.prescale & EMT_DIV32_MASK) == EMT_DIV32_MASK;
			EMT_SEL_DIV64:  tick = (state.prescale & EMT_DIV64_MASK) == EMT_DIV64_MASK;
			EMT_SEL_DIV256: tick = (state.prescale & EMT_DIV256_MASK) == EMT_DIV256_MASK;
			EMT_SEL_EXT:    tick = state.extPrev && !state.extSync[1];
		endcase
		matchNow = state.timerCountValue == state.matchLimitValue;
		if (state.countRunBit && tick)
		begin
			if (matchNow)
			begin
				next_state.timerCountValue = EMT_COUNT_RESET;
			end
			else
			begin
				next_state.timerCountValue = state.timerCountValue + 8'h01;
			end
		end
		// Match flag, a set beats a clear
		if (state.countRunBit && matchNow && state.matchLimitValue != EMT_COUNT_RESET)
		begin
			next_state.matchFlag = 1'b1;
		end
		else if (clrWrite || irqClrWrite)
		begin
			next_state.matchFlag = 1'b0;
		end
		if (ctrlWrite)
		begin
			next_state.countRunBit = rfWriteData[EMT_RUN_BIT];
			next_state.clockSelect = {rfWriteData[EMT_SEL_HI], rfWriteData[EMT_SEL_LO]};
		end
		if (clrWrite)
		begin
			next_state.timerCountValue = EMT_COUNT_RESET;
		end
		if (peripheralWriteOp && periphAddr == EMT_PR_MATCH)
		begin
			next_state.matchLimitValue = peripheralDataBufferIn;
		end
		// Read paths, registered for both buses
		if (rfAddr == EMT_RF_CTRL)
		begin
			next_state.rfRead = {state.countRunBit, 1'b0, state.clockSelect};
		end
		else if (rfAddr == EMT_RF_IRQ)
		begin
			next_state.rfRead = {3'h0, state.matchFlag};
		end
		else
		begin
			next_state.rfRead = 4'h0;
		end
		if (peripheralReadOp && periphAddr == EMT_PR_COUNT)
		begin
			next_state.dbfRead = state.timerCountValue;
		end
		else if (peripheralReadOp)
		begin
			next_state.dbfRead = 8'h00;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state <= EMT_RESET_STATE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign rfReadData = state.rfRead;
	assign peripheralDataBufferOut = state.dbfRead;
	assign timerMatchFlag = state.matchFlag;

	// ************************************************************
	// Checks
	// ************************************************************
	AST_CLEAR: assert property (@(posedge clk_sys) disable iff (srst)
		clrWrite |=> state.timerCountValue == EMT_COUNT_RESET)
		else $error("Count not cleared");
	AST_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
		(!state.countRunBit && !clrWrite) |=> $stable(state.timerCountValue))
		else $error("Count moved while stopped");
	AST_DIV32: assert property (@(posedge clk_sys) disable iff (srst)
		(state.clockSelect == EMT_SEL_DIV32 && state.countRunBit && !ctrlWrite
			&& (state.prescale & EMT_DIV32_MASK) != EMT_DIV32_MASK)
		|=> $stable(state.timerCountValue))
		else $error("Count moved off its tick");
	AST_READ: assert property (@(posedge clk_sys) disable iff (srst)
		(peripheralReadOp && periphAddr == EMT_PR_COUNT) |=> peripheralDataBufferOut == $past(state.timerCountValue))
		else $error("Count read wrong");
	AST_NOLOAD: assert property (@(posedge clk_sys) disable iff (srst)
		(peripheralReadOp && periphAddr == EMT_PR_MATCH) |=> peripheralDataBufferOut == 8'h00)
		else $error("Match value leaked");
	AST_FLAG: assert property (@(posedge clk_sys) disable iff (srst)
		(state.countRunBit && matchNow && state.matchLimitValue != 8'h00) |=> timerMatchFlag)
		else $error("Match flag not set");
	AST_WRAP: assert property (@(posedge clk_sys) disable iff (srst)
		(state.countRunBit && tick && matchNow && !clrWrite) |=> state.timerCountValue == 8'h00)
		else $error("Counter did not wrap");
	AST_MATCHWR: assert property (@(posedge clk_sys) disable iff (srst)
		(peripheralWriteOp && periphAddr == EMT_PR_MATCH) |=> state.matchLimitValue == $past(peripheralDataBufferIn))
		else $error("Match value not stored");
	AST_STEP: assert property (@(posedge clk_sys) disable iff (srst)
		(state.countRunBit && tick && !matchNow && !clrWrite)
		|=> state.timerCountValue == $past(state.timerCountValue) + 8'h01)
		else $error("Count did not step");
	AST_EXTHOLD: assert property (@(posedge clk_sys) disable iff (srst)
		(state.clockSelect == EMT_SEL_EXT && state.countRunBit && !ctrlWrite
			&& !(state.extPrev && !state.extSync[1]))
		|=> $stable(state.timerCountValue))
		else $error("Count moved without a pin edge");
	AST_NOCNTWR: assert property (@(posedge clk_sys) disable iff (srst)
		(peripheralWriteOp && periphAddr == EMT_PR_COUNT && !tick && !clrWrite)
		|=> $stable(state.timerCountValue))
		else $error("Count was loaded");
	AST_RUNWR: assert property (@(posedge clk_sys) disable iff (srst)
		ctrlWrite |=> state.countRunBit == $past(rfWriteData[EMT_RUN_BIT]))
		else $error("Run bit not taken");
	AST_CLRREAD: assert property (@(posedge clk_sys) disable iff (srst)
		(rfAddr == EMT_RF_CTRL) |=> !rfReadData[EMT_CLR_BIT])
		else $error("Clear bit read back as set");
	AST_FLAGCLR: assert property (@(posedge clk_sys) disable iff (srst)
		((clrWrite || irqClrWrite)
			&& !(state.countRunBit && matchNow && state.matchLimitValue != EMT_COUNT_RESET))
		|=> !timerMatchFlag)
		else $error("Match flag not cleared");
	AST_FLAGKEEP: assert property (@(posedge clk_sys) disable iff (srst)
		(timerMatchFlag && !clrWrite && !irqClrWrite) |=> timerMatchFlag)
		else $error("Match flag dropped");
	AST_RFIRQ: assert property (@(posedge clk_sys) disable iff (srst)
		(rfAddr == EMT_RF_IRQ) |=> rfReadData[EMT_FLAG_BIT] == $past(timerMatchFlag))
		else $error("Match flag read wrong");

	// ************************************************************
	// Cover points
	// ************************************************************
	COV_MATCH: cover property (@(posedge clk_sys) disable iff (srst) $rose(timerMatchFlag));
	COV_EXT: cover property (@(posedge clk_sys) disable iff (srst) state.clockSelect == EMT_SEL_EXT && tick);
	COV_CLR: cover property (@(posedge clk_sys) disable iff (srst) clrWrite && state.timerCountValue != 8'h00);
	COV_WRAP: cover property (@(posedge clk_sys) disable iff (srst) state.countRunBit && tick && matchNow);
	COV_IRQCLR: cover property (@(posedge clk_sys) disable iff (srst) irqClrWrite && timerMatchFlag);

endmodule

// *** core/emt_pkg.sv ***
// Constants for the eight bit modulo timer
package emt_pkg;
	localparam logic [7:0] EMT_RF_CTRL      = 8'h33;
	localparam logic [7:0] EMT_RF_IRQ       = 8'h3f;
	localparam logic [7:0] EMT_PR_COUNT     = 8'h05;
	localparam logic [7:0] EMT_PR_MATCH     = 8'h06;
	localparam int         EMT_RUN_BIT      = 3;
	localparam int         EMT_CLR_BIT      = 2;
	localparam int         EMT_SEL_HI       = 1;
	localparam int         EMT_SEL_LO       = 0;
	localparam int         EMT_FLAG_BIT     = 0;
	localparam logic [3:0] EMT_CTRL_RESET   = 4'h8;
	localparam logic [7:0] EMT_COUNT_RESET  = 8'h00;
	localparam logic [7:0] EMT_MATCH_RESET  = 8'hff;
	localparam logic [1:0] EMT_SEL_DIV32    = 2'h0;
	localparam logic [1:0] EMT_SEL_DIV64    = 2'h1;
	localparam logic [1:0] EMT_SEL_DIV256   = 2'h2;
	localparam logic [1:0] EMT_SEL_EXT      = 2'h3;
	localparam logic [7:0] EMT_DIV32_MASK   = 8'h1f;
	localparam logic [7:0] EMT_DIV64_MASK   = 8'h3f;
	localparam logic [7:0] EMT_DIV256_MASK  = 8'hff;
endpackage

// *** test/tb_emt_timer.sv ***
// Self-checking bench for the eight bit modulo timer
`timescale 1ns/1ps
module tb_emt_timer;
	import emt_pkg::*;
	logic       clk_sys = 0, srst = 1, rfWrite = 0, perWr = 0, perRd = 0, extClk = 0, timerMatchFlag;
	logic [7:0] rfAddr = 0, perAddr = 0, perIn = 0, perOut, cnt;
	logic [3:0] rfWriteData = 0, rfReadData, nib;
	int         bad_count = 0, compares = 0;
	emt_timer dut_u (.clk_sys(clk_sys), .srst(srst), .rfWrite(rfWrite), .rfAddr(rfAddr), .rfWriteData(rfWriteData),
		.rfReadData(rfReadData), .peripheralWriteOp(perWr), .peripheralReadOp(perRd), .periphAddr(perAddr),
		.peripheralDataBufferIn(perIn), .peripheralDataBufferOut(perOut), .carrierClockPin(extClk),
		.timerMatchFlag(timerMatchFlag));
	always #2 clk_sys = ~clk_sys;
	// ****************
	// Check and bus tasks
	// ****************
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task chk_true(input logic ok);
		compares++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("BAD %0t value out of range", $time);
		end
	endtask
	task rfw(input logic [7:0] a, input logic [3:0] d);
		@(negedge clk_sys);
		rfAddr = a;
		rfWriteData = d;
		rfWrite = 1'b1;
		@(negedge clk_sys);
		rfWrite = 1'b0;
	endtask
	task rfr(input logic [7:0] a);
		@(negedge clk_sys);
		rfAddr = a;
		@(negedge clk_sys);
		nib = rfReadData;
	endtask
	task pw(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		perAddr = a;
		perIn = d;
		perWr = 1'b1;
		@(negedge clk_sys);
		perWr = 1'b0;
	endtask
	task pr(input logic [7:0] a);
		@(negedge clk_sys);
		perAddr = a;
		perRd = 1'b1;
		@(negedge clk_sys);
		perRd = 1'b0;
		cnt = perOut;
	endtask
	task waitc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Pin fall reaches the count three clocks later
	task pulse(input int n);
		repeat (n)
		begin
			extClk = 1'b1;
			waitc(4);
			extClk = 1'b0;
			waitc(4);
		end
	endtask
	task conclude;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_reset;
		rfr(EMT_RF_CTRL);
		chk({4'h0, nib}, {4'h0, EMT_CTRL_RESET});
		rfr(EMT_RF_IRQ);
		chk({4'h0, nib}, 8'h00);
		pr(EMT_PR_COUNT);
		chk(cnt, EMT_COUNT_RESET);
		pr(EMT_PR_MATCH);
		chk(cnt, 8'h00);
		$display("reset values done");
	endtask
	task t_stop;
		rfw(EMT_RF_CTRL, 4'h4);
		waitc(300);
		pr(EMT_PR_COUNT);
		chk(cnt, EMT_COUNT_RESET);
		$display("stop done");
	endtask
	// Pin clock keeps every count step in the bench's hands
	task t_match;
		pw(EMT_PR_MATCH, 8'h03);
		rfw(EMT_RF_CTRL, 4'hf);
		pw(EMT_PR_COUNT, 8'h80);
		pr(EMT_PR_COUNT);
		chk(cnt, 8'h00);
		pulse(3);
		chk({7'h00, timerMatchFlag}, 8'h01);
		rfr(EMT_RF_IRQ);
		chk({4'h0, nib}, 8'h01);
		pulse(1);
		pr(EMT_PR_COUNT);
		chk(cnt, 8'h00);
		pulse(2);
		rfw(EMT_RF_CTRL, 4'hf);
		pr(EMT_PR_COUNT);
		chk(cnt, 8'h00);
		chk({7'h00, timerMatchFlag}, 8'h00);
		pulse(4);
		chk({7'h00, timerMatchFlag}, 8'h01);
		rfw(EMT_RF_IRQ, 4'h0);
		chk({7'h00, timerMatchFlag}, 8'h00);
		$display("match done");
	endtask
	task t_select;
		pw(EMT_PR_MATCH, 8'hf0);
		rfw(EMT_RF_CTRL, 4'hd);
		waitc(130);
		pr(EMT_PR_COUNT);
		chk_true(cnt >= 8'h02 && cnt <= 8'h03);
		rfw(EMT_RF_CTRL, 4'he);
		waitc(250);
		pr(EMT_PR_COUNT);
		chk_true(cnt <= 8'h01);
		rfr(EMT_RF_CTRL);
		chk({4'h0, nib}, 8'h0a);
		rfw(EMT_RF_CTRL, 4'hf);
		pulse(5);
		pr(EMT_PR_COUNT);
		chk(cnt, 8'h05);
		pr(EMT_PR_MATCH);
		chk(cnt, 8'h00);
		$display("select done");
	endtask
	// ****************
	// Main sequence
	// ****************
	initial
	begin
		waitc(8);
		srst = 1'b0;
		t_reset();
		t_stop();
		t_match();
		t_select();
		conclude();
	end
	// Tests need about 900 clocks; the limit is 5000
	initial
	begin
		#20000;
		bad_count++;
		$display("BAD %0t watchdog expired", $time);
		conclude();
	end
endmodule
